// ---- src/slcd_pkg.sv ----
// package of register map, fields and timing constants for the segment display controller
package slcd_pkg;

  // ****************************************
  // register index map (byte address = 4 * index)
  // ****************************************
  localparam logic [5:0] PIXEL_BASE_IDX   = 6'h00;
  localparam logic [5:0] SEGSEL_BASE_IDX  = 6'h18;
  localparam logic [5:0] DISP_CTRL_IDX    = 6'h1e;
  localparam logic [5:0] PRESCALE_IDX     = 6'h1f;
  localparam logic [5:0] BIAS_REF_IDX     = 6'h20;
  localparam logic [5:0] LADDER_IDX       = 6'h21;
  localparam logic [5:0] PERIPH_FLAG_IDX  = 6'h22;
  localparam logic [5:0] PERIPH_EN_IDX    = 6'h23;
  localparam logic [5:0] PERIPH_PRIO_IDX  = 6'h24;
  localparam logic [5:0] LAST_IDX         = 6'h24;

  localparam int NUM_PIXEL_REGS  = 24;
  localparam int NUM_SEGSEL_REGS = 6;
  localparam int NUM_COMMONS     = 4;
  localparam int NUM_SEGMENTS    = 48;
  localparam int SMALL_SEG_REGS  = 4;

  // ****************************************
  // field positions
  // ****************************************
  localparam int DC_ENABLE_BIT  = 7;
  localparam int DC_SLEEP_BIT   = 6;
  localparam int DC_WRITE_ERROR_FLAG_BIT    = 5;
  localparam int DC_CS_LSB      = 2;
  localparam int DC_MUX_LSB     = 0;
  localparam int PS_WFT_BIT     = 7;
  localparam int PS_BIAS_BIT    = 6;
  localparam int PS_ACTIVE_BIT  = 5;
  localparam int PS_WA_BIT      = 4;
  localparam int PS_LP_LSB      = 0;
  localparam int FRAME_IRQ_BIT  = 6;

  // writable masks; unimplemented bits read 0
  localparam logic [7:0] DC_WR_MASK  = 8'hcf;
  localparam logic [7:0] PS_WR_MASK  = 8'hcf;
  localparam logic [7:0] LAD_WR_MASK = 8'hf7;
  localparam logic [7:0] REG_RESET   = 8'h00;

  // ****************************************
  // timing: base tick of frame timing derived from core clock
  // ****************************************
  localparam int CLK_HZ        = 50_000_000;
  localparam int TICK_US       = 20;
  localparam int TICK_CYCLES   = (CLK_HZ / 1_000_000) * TICK_US;

  typedef enum logic [1:0] {
    SLCD_OKAY   = 2'h0,
    SLCD_SLVERR = 2'h2
  } slcd_resp_t;

endpackage

// ---- src/slcd_top.sv ----
// segment display controller: register file, frame timing and pin drive
//
// Contract
// [R1] software sets frame_prescale first
// [R2] software enables segment pins before display
// [R3] software sets ladder_a_interval for internal ladder
// [R4] software sets ladder A/B power levels
// [R5] software sets bias pins and ladder enable
// [R6] software sets mux, timing source, sleep
// [R7] software loads all 24 pixel registers
// [R8] software clears frame flag, optionally enables
// [R9] software sets display_enable last
// [R10] pixel reg 6c+k bit n = com c seg 8k+n
// [R11] display_control field layout, bit 4 zero
// [R12] prescale_waveform_control field layout
// [R13] bias_reference_control field layout
// [R14] resistor_ladder_control layout, bit 3 zero
// [R15] six segment enable regs, 48 pins
// [R16] small package keeps upper pixel regs as storage
// [R17] small package drops upper segment enables
// [R18] frame_irq_priority at bit 6 priority reg
// [R19] disallowed pixel write sets write_error_flag
// [R20] common_mux_select resets to 00
// [R21] segment enable overrides port direction
// [R22] frame timing runs only while enabled
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module slcd_top #(
  parameter bit SMALL_PKG = 1'b0
) (
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic [1:0]       avs_response_o,
  input  wire logic        sleep_req_i,
  input  wire logic [47:0] port_dir_i,
  output logic [47:0]      seg_pin_oe_o,
  output logic [47:0]      seg_level_o,
  output logic [3:0]       com_level_o,
  output logic [3:0]       com_active_o,
  output logic             frame_irq_o,
  output logic             frame_irq_prio_o,
  output logic [2:0]       bias_pin_en_o,
  output logic             ladder_en_o
);

  // ****************************************
  // register storage
  // ****************************************
  logic [7:0] pixel_mem [slcd_pkg::NUM_PIXEL_REGS];
  logic [7:0] segsel    [slcd_pkg::NUM_SEGSEL_REGS];
  logic [7:0] display_control;
  logic [7:0] prescale_waveform_control;
  logic [7:0] bias_reference_control;
  logic [7:0] resistor_ladder_control;
  logic       frame_irq_flag;
  logic       frame_irq_enable;
  logic       frame_irq_priority;

  // pixel memory has no reset: software loads every byte before enabling

  logic [5:0] idx;
  logic       ack;
  logic       wr_go;
  logic       rd_go;
  logic       in_range;
  logic       lane_ok;
  logic       is_pixel;
  logic       is_segsel;
  logic [4:0] pix_idx;
  logic [2:0] seg_idx;
  logic       write_allowed;
  logic       display_active;
  logic       frame_event;
  logic       sleep_s1;
  logic       sleep_s2;

  assign idx      = avs_address_i[7:2];
  assign in_range = (avs_address_i[1:0] == 2'h0) && (idx <= slcd_pkg::LAST_IDX);
  assign lane_ok  = avs_byteenable_i[0];
  assign is_pixel = idx < slcd_pkg::SEGSEL_BASE_IDX;
  assign is_segsel = (idx >= slcd_pkg::SEGSEL_BASE_IDX) && (idx < slcd_pkg::DISP_CTRL_IDX);
  assign pix_idx  = idx[4:0];
  assign seg_idx  = 3'(idx - slcd_pkg::SEGSEL_BASE_IDX);

  // ****************************************
  // avalon slave: one wait state, answer on second cycle
  // ****************************************
  // waitrequest drops one cycle after request so reads come from flops
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read_i || avs_write_i) && !ack;
    end
  end

  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
  assign wr_go = avs_write_i && ack;
  assign rd_go = avs_read_i && !ack;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      avs_response_o <= slcd_pkg::SLCD_OKAY;
    end else if (avs_read_i || avs_write_i) begin
      avs_response_o <= in_range ? slcd_pkg::SLCD_OKAY : slcd_pkg::SLCD_SLVERR;
    end
  end

  // ****************************************
  // sleep request synchroniser
  // ****************************************
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sleep_s1 <= 1'b0;
      sleep_s2 <= 1'b0;
    end else begin
      sleep_s1 <= sleep_req_i;
      sleep_s2 <= sleep_s1;
    end
  end

  // ****************************************
  // pixel and segment enable registers
  // ****************************************
  // upper pixel regs stay on small package as plain storage
  always_ff @(posedge core_clk_i) begin
    if (wr_go && in_range && lane_ok && is_pixel && write_allowed) begin
      pixel_mem[pix_idx] <= avs_writedata_i[7:0]; // [R10] [R16]
    end
  end

  for (genvar k = 0; k < slcd_pkg::NUM_SEGSEL_REGS; k++) begin : g_segsel
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        segsel[k] <= slcd_pkg::REG_RESET;
      end else if (SMALL_PKG && k >= slcd_pkg::SMALL_SEG_REGS) begin
        segsel[k] <= slcd_pkg::REG_RESET; // [R17]
      end else if (wr_go && in_range && lane_ok && is_segsel && seg_idx == 3'(k)) begin
        segsel[k] <= avs_writedata_i[7:0]; // [R15]
      end
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      display_control <= slcd_pkg::REG_RESET; // [R20]
    end else begin
      if (wr_go && in_range && lane_ok && idx == slcd_pkg::DISP_CTRL_IDX) begin
        display_control <= avs_writedata_i[7:0] & slcd_pkg::DC_WR_MASK; // [R11]
      end
      // pixel write while disallowed: set beats same-cycle clear
      if (wr_go && in_range && lane_ok && is_pixel && !write_allowed) begin
        display_control[slcd_pkg::DC_WRITE_ERROR_FLAG_BIT] <= 1'b1; // [R19]
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prescale_waveform_control <= slcd_pkg::REG_RESET;
      bias_reference_control    <= slcd_pkg::REG_RESET;
      resistor_ladder_control   <= slcd_pkg::REG_RESET;
      frame_irq_enable          <= 1'b0;
      frame_irq_priority        <= 1'b0;
    end else if (wr_go && in_range && lane_ok) begin
      unique case (idx)
        slcd_pkg::PRESCALE_IDX:
          prescale_waveform_control <= avs_writedata_i[7:0] & slcd_pkg::PS_WR_MASK; // [R12]
        slcd_pkg::BIAS_REF_IDX:
          bias_reference_control <= avs_writedata_i[7:0]; // [R13]
        slcd_pkg::LADDER_IDX:
          resistor_ladder_control <= avs_writedata_i[7:0] & slcd_pkg::LAD_WR_MASK; // [R14]
        slcd_pkg::PERIPH_EN_IDX:
          frame_irq_enable <= avs_writedata_i[slcd_pkg::FRAME_IRQ_BIT];
        slcd_pkg::PERIPH_PRIO_IDX:
          frame_irq_priority <= avs_writedata_i[slcd_pkg::FRAME_IRQ_BIT]; // [R18]
        default: ;
      endcase
    end
  end

  // frame flag: hardware set wins over software clear
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      frame_irq_flag <= 1'b0;
    end else if (frame_event) begin
      frame_irq_flag <= 1'b1;
    end else if (wr_go && in_range && lane_ok && idx == slcd_pkg::PERIPH_FLAG_IDX) begin
      frame_irq_flag <= avs_writedata_i[slcd_pkg::FRAME_IRQ_BIT];
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (is_pixel) begin
      rd_byte = pixel_mem[pix_idx];
    end else if (is_segsel) begin
      rd_byte = segsel[seg_idx];
    end else begin
      unique case (idx)
        slcd_pkg::DISP_CTRL_IDX: rd_byte = display_control;
        slcd_pkg::PRESCALE_IDX: begin
          rd_byte = prescale_waveform_control;
          rd_byte[slcd_pkg::PS_ACTIVE_BIT] = display_active;
          rd_byte[slcd_pkg::PS_WA_BIT]     = write_allowed;
        end
        slcd_pkg::BIAS_REF_IDX:    rd_byte = bias_reference_control;
        slcd_pkg::LADDER_IDX:      rd_byte = resistor_ladder_control;
        slcd_pkg::PERIPH_FLAG_IDX: rd_byte = {1'b0, frame_irq_flag, 6'h00};
        slcd_pkg::PERIPH_EN_IDX:   rd_byte = {1'b0, frame_irq_enable, 6'h00};
        slcd_pkg::PERIPH_PRIO_IDX: rd_byte = {1'b0, frame_irq_priority, 6'h00};
        default:                   rd_byte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (rd_go) begin
      avs_readdata_o <= in_range ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // ****************************************
  // frame timing generator
  // ****************************************
  localparam int TICK_W = $clog2(slcd_pkg::TICK_CYCLES);
  logic [TICK_W-1:0] tick_cnt;
  logic              tick;
  logic [3:0]        pre_cnt;
  logic [1:0]        com_idx;
  logic              phase;
  logic              run;
  logic [1:0]        last_com;

  assign last_com = display_control[slcd_pkg::DC_MUX_LSB +: 2];
  // sleep with stop enabled halts the module like a cleared enable
  assign run = display_control[slcd_pkg::DC_ENABLE_BIT]
             && !(sleep_s2 && display_control[slcd_pkg::DC_SLEEP_BIT]); // [R22]
  assign display_active = run;
  // type-b multiplexed allows writes only in the slot after frame event
  logic wr_window;
  assign write_allowed = !run || !prescale_waveform_control[slcd_pkg::PS_WFT_BIT]
                       || last_com == 2'h0 || wr_window;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (!run) begin
      tick_cnt <= '0; // [R22]
      tick     <= 1'b0;
    end else if (tick_cnt == TICK_W'(slcd_pkg::TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick     <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pre_cnt     <= 4'h0;
      com_idx     <= 2'h0;
      phase       <= 1'b0;
      frame_event <= 1'b0;
      wr_window   <= 1'b0;
    end else if (!run) begin
      pre_cnt     <= 4'h0;
      com_idx     <= 2'h0;
      phase       <= 1'b0;
      frame_event <= 1'b0;
      wr_window   <= 1'b0;
    end else begin
      frame_event <= 1'b0;
      if (tick) begin
        if (pre_cnt == prescale_waveform_control[slcd_pkg::PS_LP_LSB +: 4]) begin
          pre_cnt   <= 4'h0;
          wr_window <= 1'b0;
          if (com_idx == last_com) begin
            com_idx <= 2'h0;
            phase   <= !phase;
            frame_event <= prescale_waveform_control[slcd_pkg::PS_WFT_BIT]
                         && last_com != 2'h0 && phase;
            wr_window <= prescale_waveform_control[slcd_pkg::PS_WFT_BIT] && phase;
          end else begin
            com_idx <= com_idx + 2'h1;
          end
        end else begin
          pre_cnt <= pre_cnt + 4'h1;
        end
      end
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  logic [7:0] pixel_row [slcd_pkg::NUM_SEGSEL_REGS];
  for (genvar k = 0; k < slcd_pkg::NUM_SEGSEL_REGS; k++) begin : g_pins
    assign pixel_row[k] = pixel_mem[5'(6 * com_idx + k)]; // [R10]
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        seg_level_o[8*k +: 8] <= 8'h00;
      end else begin
        seg_level_o[8*k +: 8] <= run ? ((pixel_row[k] ^ {8{phase}}) & segsel[k]) : 8'h00; // [R22]
      end
    end
    // set enable forces segment drive whatever the direction bit
    assign seg_pin_oe_o[8*k +: 8] = segsel[k] | ~port_dir_i[8*k +: 8]; // [R21]
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      com_level_o  <= 4'h0;
      com_active_o <= 4'h0;
    end else begin
      com_level_o  <= run ? (4'h1 << com_idx) ^ {4{phase}} : 4'h0; // [R22]
      com_active_o <= run ? 4'((5'h2 << last_com) - 5'h1) : 4'h0;
    end
  end

  assign frame_irq_o      = frame_irq_flag && frame_irq_enable;
  assign frame_irq_prio_o = frame_irq_priority;
  assign bias_pin_en_o    = bias_reference_control[2:0];
  assign ladder_en_o      = bias_reference_control[7];

  // ****************************************
  // checks
  // ****************************************
  write_error_flag_set_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // [R19]
    wr_go && in_range && lane_ok && is_pixel && !write_allowed
    |=> display_control[slcd_pkg::DC_WRITE_ERROR_FLAG_BIT])
    else $error("write error flag not set");

  halt_off_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // [R22]
    !run |=> (seg_level_o == 48'h0 && com_level_o == 4'h0))
    else $error("pins driven while display disabled");

  unimp_zero_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // [R11] [R14]
    display_control[4] == 1'b0 && resistor_ladder_control[3] == 1'b0)
    else $error("unimplemented bit set");

  oe_override_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // [R21]
    (seg_pin_oe_o & {segsel[5], segsel[4], segsel[3], segsel[2], segsel[1], segsel[0]})
    == {segsel[5], segsel[4], segsel[3], segsel[2], segsel[1], segsel[0]})
    else $error("segment enable did not override direction");

  small_pkg_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // [R17]
    SMALL_PKG |-> segsel[4] == 8'h00 && segsel[5] == 8'h00)
    else $error("upper segment enables present on small package");

  flag_set_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    frame_event |=> frame_irq_flag)
    else $error("frame flag lost");

endmodule

// ---- verif/slcd_panel_model.sv ----
// passive glass panel model: counts frames seen on common line 0
`timescale 1ns/1ps
module slcd_panel_model (
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic [3:0]  com_level_i,
  input  wire logic [3:0]  com_active_i,
  output logic [15:0]      frame_cnt_o
);
  // ****************************************
  // frame counting
  // ****************************************
  logic common_line_zero_q;

  // glass drives nothing back; common 0 changes level once per frame in every mux mode: the phase flip
  // does it in static mode, else the end of its select slot, as slot and phase cancel at the wrap; so each change is a frame
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      common_line_zero_q      <= 1'b0;
      frame_cnt_o <= 16'h0000;
    end else begin
      common_line_zero_q <= com_level_i[0];
      if (com_active_i[0] && (com_level_i[0] != common_line_zero_q)) begin
        frame_cnt_o <= frame_cnt_o + 16'h0001;
      end
    end
  end
endmodule

// ---- verif/test_slcd_top.sv ----
// self-checking bench for the segment display controller
`timescale 1ns/1ps
module test_slcd_top;
  // ****************************************
  // signals
  // ****************************************
  logic        core_clk_i;
  logic        nrst_i;
  logic [7:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [1:0]  avs_response_o;
  logic        sleep_req_i;
  logic [47:0] port_dir_i;
  logic [47:0] seg_pin_oe_o;
  logic [47:0] seg_level_o;
  logic [3:0]  com_level_o;
  logic [3:0]  com_active_o;
  logic        frame_irq_o;
  logic        frame_irq_prio_o;
  logic [2:0]  bias_pin_en_o;
  logic        ladder_en_o;
  logic [15:0] frame_cnt;
  logic [15:0] frames_seen;
  logic [7:0]  rd_data;
  logic [1:0]  rd_resp;
  int          error_cnt;
  int          total_checks;
  int          cycle_cnt;
  int          n;
  typedef struct packed {logic [5:0] idx; logic [7:0] wr; logic [7:0] exp;} slcd_row_t;
  slcd_row_t   rows [13];

  slcd_top slcd_top_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .avs_response_o(avs_response_o), .sleep_req_i(sleep_req_i), .port_dir_i(port_dir_i),
    .seg_pin_oe_o(seg_pin_oe_o), .seg_level_o(seg_level_o), .com_level_o(com_level_o),
    .com_active_o(com_active_o), .frame_irq_o(frame_irq_o),
    .frame_irq_prio_o(frame_irq_prio_o), .bias_pin_en_o(bias_pin_en_o),
    .ladder_en_o(ladder_en_o));

  slcd_panel_model slcd_panel_model_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .com_level_i(com_level_o), .com_active_i(com_active_o), .frame_cnt_o(frame_cnt));

  // ****************************************
  // clock, timeout, report
  // ****************************************
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // longest run is a few frame waits of some thousand cycles each
  always @(posedge core_clk_i) begin
    cycle_cnt++;
    if (cycle_cnt == 90000) begin
      error_cnt++;
      $display("BAD t=%0t timeout", $time);
      give_verdict();
    end
  end

  task automatic bad(input string what);
    error_cnt++;
    $display("BAD t=%0t %s", $time, what);
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) bad($sformatf("%s got %h exp %h", what, got, exp));
  endtask

  task automatic chk_vec(input logic [47:0] got, input logic [47:0] exp, input string what);
    total_checks++;
    if (got !== exp) bad($sformatf("%s got %h exp %h", what, got, exp));
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
    total_checks++;
    if (got !== exp) bad($sformatf("%s resp %h exp %h", what, got, exp));
  endtask

  // ****************************************
  // bus master
  // ****************************************
  // request already set up; hold it until waitrequest is seen low, then release
  task automatic bus_go();
    int w;
    w = 0;
    @(posedge core_clk_i);
    while (avs_waitrequest_o !== 1'b0 && w < 100) begin
      @(posedge core_clk_i);
      w++;
    end
    if (w == 100) bad("bus hang");
    rd_data = avs_readdata_o[7:0];
    rd_resp = avs_response_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic bus_wr(input logic [5:0] idx, input logic [7:0] d);
    avs_address_i   <= {idx, 2'b00};
    avs_writedata_i <= {24'h000000, d};
    avs_write_i     <= 1'b1;
    bus_go();
  endtask

  task automatic bus_rd(input logic [5:0] idx);
    avs_address_i <= {idx, 2'b00};
    avs_read_i    <= 1'b1;
    bus_go();
  endtask

  task automatic wait_frames(input logic [15:0] k, input int lim);
    for (n = 0; n < lim && frame_cnt < frames_seen + k; n++) @(posedge core_clk_i);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    nrst_i = 1'b0;
    avs_address_i = 8'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h00000000;
    avs_byteenable_i = 4'h1;
    sleep_req_i = 1'b0;
    port_dir_i = 48'hffff_ffff_0000;
    error_cnt = 0;
    total_checks = 0;
    cycle_cnt = 0;
    rows[0] = {slcd_pkg::PRESCALE_IDX, 8'hff, 8'hdf};
    for (int k = 0; k < 6; k++)
      rows[1 + k] = {slcd_pkg::SEGSEL_BASE_IDX + 6'(k), 8'(8'ha5 ^ (8'h33 * k)),
                     8'(8'ha5 ^ (8'h33 * k))};
    rows[7]  = {slcd_pkg::LADDER_IDX, 8'hff, 8'hf7};
    rows[8]  = {slcd_pkg::BIAS_REF_IDX, 8'hff, 8'hff};
    rows[9]  = {slcd_pkg::DISP_CTRL_IDX, 8'h5f, 8'h4f};
    rows[10] = {slcd_pkg::PERIPH_FLAG_IDX, 8'h40, 8'h40};
    rows[11] = {slcd_pkg::PERIPH_EN_IDX, 8'h40, 8'h40};
    rows[12] = {slcd_pkg::PERIPH_PRIO_IDX, 8'h40, 8'h40};
    repeat (8) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    @(posedge core_clk_i);
    bus_rd(slcd_pkg::DISP_CTRL_IDX);
    chk_byte(rd_data, 8'h00, "display_control reset");
    for (int r = 0; r < 13; r++) begin
      bus_wr(rows[r].idx, rows[r].wr);
      bus_rd(rows[r].idx);
      chk_byte(rd_data, rows[r].exp, "register row");
      chk_resp(rd_resp, 2'h0, "register row");
    end
    chk_vec({47'h0, frame_irq_o}, 48'h1, "irq flag and enable");
    chk_vec({45'h0, bias_pin_en_o}, 48'h7, "bias pins");
    chk_vec({47'h0, ladder_en_o}, 48'h1, "ladder enable");
    chk_vec({47'h0, frame_irq_prio_o}, 48'h1, "irq priority");
    chk_vec(seg_pin_oe_o, 48'h5a_69_3c_c3_96_a5 | ~port_dir_i, "segment override");
    bus_wr(slcd_pkg::PERIPH_FLAG_IDX, 8'h00);
    chk_vec({47'h0, frame_irq_o}, 48'h0, "irq after clear");
    for (int p = 0; p < 24; p++) begin
      bus_wr(slcd_pkg::PIXEL_BASE_IDX + 6'(p), 8'(p * 7 + 3));
    end
    for (int p = 0; p < 24; p++) begin
      bus_rd(slcd_pkg::PIXEL_BASE_IDX + 6'(p));
      chk_byte(rd_data, 8'(p * 7 + 3), "pixel readback");
    end
    bus_rd(6'h3f);
    chk_resp(rd_resp, 2'h2, "unmapped");
    chk_byte(rd_data, 8'h00, "unmapped data");
    // no frames may appear while the display is off
    bus_wr(slcd_pkg::DISP_CTRL_IDX, 8'h03);
    bus_wr(slcd_pkg::PRESCALE_IDX, 8'h00);
    frames_seen = frame_cnt;
    wait_frames(16'd1, 6000);
    chk_vec({32'h0, frame_cnt}, 48'h0, "frames while off");
    bus_wr(slcd_pkg::DISP_CTRL_IDX, 8'h83);
    wait_frames(16'd2, 15000);
    chk_vec({47'h0, frame_cnt >= 16'd2}, 48'h1, "frames while on");
    bus_rd(slcd_pkg::PRESCALE_IDX);
    chk_byte(rd_data, 8'h30, "active, type A writable");
    // sleep with stop enabled halts; the request passes two flops first
    bus_wr(slcd_pkg::DISP_CTRL_IDX, 8'hc3);
    sleep_req_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    bus_rd(slcd_pkg::PRESCALE_IDX);
    chk_byte(rd_data, 8'h10, "sleep halts");
    sleep_req_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    bus_rd(slcd_pkg::PRESCALE_IDX);
    chk_byte(rd_data, 8'h30, "wake resumes");
    bus_wr(slcd_pkg::DISP_CTRL_IDX, 8'h03);
    for (n = 0; n < 3000 && rd_data[5] !== 1'b0; n++) bus_rd(slcd_pkg::PRESCALE_IDX);
    chk_byte(rd_data, 8'h10, "halted");
    frames_seen = frame_cnt;
    repeat (5000) @(posedge core_clk_i);
    chk_vec({32'h0, frame_cnt}, {32'h0, frames_seen}, "no frames after halt");
    // type B multiplexed: writing before any frame event is refused
    bus_wr(slcd_pkg::PRESCALE_IDX, 8'h80);
    bus_wr(slcd_pkg::DISP_CTRL_IDX, 8'h83);
    bus_wr(slcd_pkg::PIXEL_BASE_IDX + 6'd1, 8'h5a);
    bus_rd(slcd_pkg::DISP_CTRL_IDX);
    chk_byte(rd_data, 8'ha3, "write error set");
    bus_rd(slcd_pkg::PIXEL_BASE_IDX + 6'd1);
    chk_byte(rd_data, 8'h0a, "refused pixel kept");
    for (n = 0; n < 30000 && frame_irq_o !== 1'b1; n++) @(posedge core_clk_i);
    chk_vec({47'h0, frame_irq_o}, 48'h1, "frame irq");
    bus_wr(slcd_pkg::PERIPH_EN_IDX, 8'h00);
    chk_vec({47'h0, frame_irq_o}, 48'h0, "irq masked");
    // reset in mid-run clears control and stops the commons
    nrst_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    @(posedge core_clk_i);
    chk_vec({44'h0, com_active_o}, 48'h0, "commons after reset");
    bus_rd(slcd_pkg::DISP_CTRL_IDX);
    chk_byte(rd_data, 8'h00, "display_control after reset");
    give_verdict();
  end
endmodule
